// ---- hdl/ptb_pkg.sv ----
package ptb_pkg;
   // Array geometry.
   localparam int N_IN       = 68;
   localparam int N_LINE     = 136;
   localparam int N_LTERM    = 160;
   localparam int N_TERM     = 163;
   localparam int N_MC       = 32;
   localparam int CL_SIZE    = 5;
   localparam int SHARE_SPAN = 3;
   localparam int SHARE_W    = 7;
   localparam int N_GCLK     = 3;
   localparam int N_EXT_FB   = 16;
   localparam int N_BLK_OUT  = 48;
   localparam int N_POOL     = 384;
   localparam int N_GLOBAL   = 192;
   localparam int SEL_W      = 9;
   localparam int TERM_WORDS = 5;
   localparam int TERM_BITS  = 160;

   // Control product term indices behind the logic terms.
   localparam int PT_CLK = 160;
   localparam int PT_RST = 161;
   localparam int PT_OE  = 162;
   // Terms inside a cluster that double as per-macrocell controls.
   localparam int CL_PRE_TERM = 3;
   localparam int CL_CE_TERM  = 4;

   // Register map: region tags of the upper address bits, then full byte addresses.
   localparam logic [2:0]  TERM_REGION = 3'h0;
   localparam logic [8:0]  MC_REGION   = 9'h040;
   localparam logic [6:0]  SEL_REGION  = 7'h14;
   localparam logic [15:0] EXP_ADDR    = 16'h3000;
   localparam logic [15:0] STAT_A_ADDR = 16'h3004;
   localparam logic [15:0] STAT_B_ADDR = 16'h3008;
   localparam logic [15:0] STAT_IN_ADDR = 16'h300C;

   // Macrocell configuration word fields.
   localparam int MC_SHARE  = 0;
   localparam int MC_BYPASS = 7;
   localparam int MC_XOR    = 8;
   localparam int MC_REG    = 9;
   localparam int MC_LATCH  = 10;
   localparam int MC_CLK    = 11;
   localparam int MC_CE_USE = 13;
   localparam int MC_CE_PT  = 14;
   localparam int MC_RST_G  = 15;
   localparam int MC_RST_PT = 16;
   localparam int MC_PRE_G  = 17;
   localparam int MC_PRE_PT = 18;
   localparam int MC_D_IO   = 19;
   localparam int MC_OE_PT  = 20;

   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] RD_ZERO   = 32'h0000_0000;
endpackage

// ---- hdl/ptb_macrocell.sv ----
`timescale 1ns/1ns
module ptb_macrocell (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic d,
   input  wire logic clk_lvl,
   input  wire logic latch_mode,
   input  wire logic ce,
   input  wire logic rst,
   input  wire logic pre,
   output logic      q
);
   typedef struct packed {
      logic q;
      logic clk_prev;
   } ptb_mc_s;

   ptb_mc_s r_reg;
   ptb_mc_s r_next;

   always_comb begin
      r_next          = r_reg;
      r_next.clk_prev = clk_lvl;
      if (rst) begin
         r_next.q = 1'b0;                                          // [RQ20]
      end else if (pre) begin
         r_next.q = 1'b1;                                          // [RQ14]
      end else if (ce) begin                                       // [RQ13]
         if (latch_mode) begin
            if (clk_lvl) begin
               r_next.q = d;                                       // [RQ15]
            end
         end else if (clk_lvl && !r_reg.clk_prev) begin
            r_next.q = d;                                          // [RQ15]
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // Reset and preset reach the output at once, without waiting for a clock.
   assign q = rst ? 1'b0 : (pre ? 1'b1 : r_reg.q);                 // [RQ20]
endmodule

// ---- hdl/ptb_logic_block.sv ----
// What this block does
// [RQ1] Block holds 32 macrocells, 160 logic terms and three control terms.
// [RQ2] 68 inputs in true and inverted form wire-AND into any of 163 terms.
// [RQ3] Control terms are shared clock, shared reset and shared output enable.
// [RQ4] Logic terms form clusters of five feeding sharing array or macrocell.
// [RQ5] Sharing array ORs any subset of seven OR inputs per macrocell output.
// [RQ6] Output N draws on OR inputs N-3 to N+3, wrapping modulo 32.
// [RQ7] Without expansion one sharing pass combines at most 35 terms.
// [RQ8] Expanders with sharing array combine up to 160 terms into one macrocell.
// [RQ9] Macrocell takes sharing or bypass logic, XOR, then register or pass.
// [RQ10] Each macrocell has two independent outputs, registered and combinational.
// [RQ11] Storage element can load directly from its I/O cell input.
// [RQ12] Storage clock selects among global clocks and product term clock.
// [RQ13] Clock enable from global signal or product term, no gated clock.
// [RQ14] Reset and preset come from global or product term signals.
// [RQ15] Storage element is either edge D flip-flop or level D latch.
// [RQ16] Block sends 32 internal and 16 external feedback outputs, 48 total.
// [RQ17] Segment pool carries 384 signals, 48 per block plus 192 global.
// [RQ18] Block outputs drive segment and global pools, reaching any block.
// [RQ19] Every global pool signal may reach any segment pool.
// [RQ20] Reset or preset overrides data and enable asynchronously; reset wins.
`timescale 1ns/1ns
module ptb_logic_block (
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [15:0]                     paddr,
   input  wire logic [31:0]                     pwdata,
   output logic      [31:0]                     prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   input  wire logic [ptb_pkg::N_POOL-1:0]      pool_in,
   input  wire logic [ptb_pkg::N_GCLK-1:0]      gclk_pin,
   input  wire logic                            gce_pin,
   input  wire logic                            grst_pin,
   input  wire logic                            gpre_pin,
   input  wire logic                            goe_pin,
   input  wire logic [ptb_pkg::N_MC-1:0]        io_in_pin,
   output logic      [ptb_pkg::N_MC-1:0]        mc_out_a,
   output logic      [ptb_pkg::N_MC-1:0]        mc_out_b,
   output logic      [ptb_pkg::N_MC-1:0]        io_oe,
   output logic      [ptb_pkg::N_BLK_OUT-1:0]   pool_out
);
   localparam int NSYNC = ptb_pkg::N_GCLK + 4 + ptb_pkg::N_MC;

   typedef struct packed {
      logic [ptb_pkg::N_TERM-1:0][ptb_pkg::TERM_BITS-1:0] term_mask;
      logic [ptb_pkg::N_MC-1:0][31:0]                     mc_cfg;
      logic [ptb_pkg::N_IN-1:0][ptb_pkg::SEL_W-1:0]       in_sel;
      logic [ptb_pkg::N_MC-1:0]                           exp_en;
      logic [31:0]                                        prdata;
      logic                                               pslverr;
      logic [NSYNC-1:0]                                   sync1;
      logic [NSYNC-1:0]                                   sync2;
   } ptb_blk_s;

   ptb_blk_s r_reg;
   ptb_blk_s r_next;

   logic [ptb_pkg::N_IN-1:0]      blk_in;
   logic [ptb_pkg::N_LINE-1:0]    line;
   logic [ptb_pkg::N_TERM-1:0]    term;
   logic [ptb_pkg::N_MC-1:0]      cluster;
   logic [ptb_pkg::N_MC-1:0]      exp_or;
   logic [ptb_pkg::N_MC-1:0]      or_in;
   logic [ptb_pkg::N_MC-1:0]      share_out;
   logic [ptb_pkg::N_MC-1:0]      comb_val;
   logic [ptb_pkg::N_MC-1:0]      store_q;
   logic [ptb_pkg::N_GCLK-1:0]    gclk_s;
   logic                          gce_s;
   logic                          grst_s;
   logic                          gpre_s;
   logic                          goe_s;
   logic [ptb_pkg::N_MC-1:0]      io_s;
   logic                          setup_ph;
   logic                          wr_en;
   logic [7:0]                    t_idx;
   logic [2:0]                    w_idx;
   logic [4:0]                    mc_idx;
   logic [6:0]                    sel_idx;
   logic                          hit_term;
   logic                          hit_mc;
   logic                          hit_sel;
   logic                          hit_reg;
   logic [31:0]                   rd_word;

   // Pin inputs pass two flops; only the second stage is read.
   assign {io_s, goe_s, gpre_s, grst_s, gce_s, gclk_s} = r_reg.sync2;

   // Input routing: each block input picks one pool signal, global pool included.
   genvar gi;
   generate
      for (gi = 0; gi < ptb_pkg::N_IN; gi++) begin : g_in
         logic [ptb_pkg::SEL_W-1:0] sel;
         assign sel = r_reg.in_sel[gi];
         // Out-of-range selections read as zero.
         assign blk_in[gi] = (32'(sel) < ptb_pkg::N_POOL) ? pool_in[sel] : 1'b0; // [RQ17] [RQ19]
         assign line[2*gi]   = blk_in[gi];                         // [RQ2]
         assign line[2*gi+1] = ~blk_in[gi];                        // [RQ2]
      end
   endgenerate

   // Wired-AND array: a term is one only if every connected line is one.
   generate
      for (gi = 0; gi < ptb_pkg::N_TERM; gi++) begin : g_term
         assign term[gi] = &(~r_reg.term_mask[gi][ptb_pkg::N_LINE-1:0] | line); // [RQ1] [RQ2]
      end
   endgenerate

   // Clusters, expander chain and sharing array.
   generate
      for (gi = 0; gi < ptb_pkg::N_MC; gi++) begin : g_share
         logic [ptb_pkg::SHARE_W-1:0] taps;
         assign cluster[gi] = |term[gi*ptb_pkg::CL_SIZE +: ptb_pkg::CL_SIZE]; // [RQ4]
         // The chain runs one way only, so it can never close a loop.
         if (gi == 0) begin : g_first
            assign exp_or[gi] = cluster[gi];
         end else begin : g_chain
            assign exp_or[gi] = cluster[gi] | (r_reg.exp_en[gi] & exp_or[gi-1]); // [RQ8]
         end
         // A bypassed cluster leaves the sharing array, but still passes along the expander chain to the next macrocell.
         assign or_in[gi] = ~r_reg.mc_cfg[gi][ptb_pkg::MC_BYPASS] & exp_or[gi]; // [RQ4]
         for (genvar j = 0; j < ptb_pkg::SHARE_W; j++) begin : g_tap
            localparam int SRC = (gi + j - ptb_pkg::SHARE_SPAN + ptb_pkg::N_MC) % ptb_pkg::N_MC;
            assign taps[j] = or_in[SRC];                           // [RQ6]
         end
         // Seven taps of five terms bound a single pass to 35 terms.
         assign share_out[gi] = |(taps & r_reg.mc_cfg[gi][ptb_pkg::MC_SHARE +: ptb_pkg::SHARE_W]); // [RQ5] [RQ7]
      end
   endgenerate

   // Macrocells.
   generate
      for (gi = 0; gi < ptb_pkg::N_MC; gi++) begin : g_mc
         logic [31:0] cfg;
         logic        sum;
         logic        d_in;
         logic        clk_lvl;
         logic        ce;
         logic        rst;
         logic        pre;
         assign cfg = r_reg.mc_cfg[gi];
         assign sum = cfg[ptb_pkg::MC_BYPASS] ? cluster[gi] : share_out[gi]; // [RQ9]
         assign comb_val[gi] = sum ^ cfg[ptb_pkg::MC_XOR];         // [RQ9]
         assign d_in = cfg[ptb_pkg::MC_D_IO] ? io_s[gi] : comb_val[gi]; // [RQ11]
         always_comb begin
            case (cfg[ptb_pkg::MC_CLK +: 2])                       // [RQ12]
               2'h0:    clk_lvl = gclk_s[0];
               2'h1:    clk_lvl = gclk_s[1];
               2'h2:    clk_lvl = gclk_s[2];
               default: clk_lvl = term[ptb_pkg::PT_CLK];           // [RQ3]
            endcase
         end
         assign ce = ~cfg[ptb_pkg::MC_CE_USE]
                   | (cfg[ptb_pkg::MC_CE_PT]
                      ? term[gi*ptb_pkg::CL_SIZE + ptb_pkg::CL_CE_TERM] : gce_s); // [RQ13]
         assign rst = (cfg[ptb_pkg::MC_RST_G] & grst_s)
                    | (cfg[ptb_pkg::MC_RST_PT] & term[ptb_pkg::PT_RST]); // [RQ3] [RQ14]
         assign pre = (cfg[ptb_pkg::MC_PRE_G] & gpre_s)
                    | (cfg[ptb_pkg::MC_PRE_PT]
                       & term[gi*ptb_pkg::CL_SIZE + ptb_pkg::CL_PRE_TERM]); // [RQ14]
         ptb_macrocell u_mc (
            .pclk       (pclk),
            .presetn    (presetn),
            .d          (d_in),
            .clk_lvl    (clk_lvl),
            .latch_mode (cfg[ptb_pkg::MC_LATCH]),
            .ce         (ce),
            .rst        (rst),
            .pre        (pre),
            .q          (store_q[gi])
         );
         assign mc_out_a[gi] = cfg[ptb_pkg::MC_REG] ? store_q[gi] : comb_val[gi]; // [RQ9] [RQ10]
         assign mc_out_b[gi] = comb_val[gi];                       // [RQ10]
         assign io_oe[gi] = cfg[ptb_pkg::MC_OE_PT] ? term[ptb_pkg::PT_OE] : goe_s; // [RQ3]
      end
   endgenerate

   // Feedback to the pools: macrocell outputs plus the external I/O feedback.
   assign pool_out = {io_s[ptb_pkg::N_EXT_FB-1:0], mc_out_a};    // [RQ16] [RQ18]

   // Register bus decode.
   assign setup_ph = psel & ~penable;
   assign pready   = psel & penable;
   assign wr_en    = psel & penable & pwrite;
   assign t_idx    = paddr[12:5];
   assign w_idx    = paddr[4:2];
   assign mc_idx   = paddr[6:2];
   assign sel_idx  = paddr[8:2];
   assign hit_term = (paddr[15:13] == ptb_pkg::TERM_REGION)
                   && (32'(t_idx) < ptb_pkg::N_TERM)
                   && (32'(w_idx) < ptb_pkg::TERM_WORDS)
                   && (paddr[1:0] == 2'h0);
   assign hit_mc   = (paddr[15:7] == ptb_pkg::MC_REGION) && (paddr[1:0] == 2'h0);
   assign hit_sel  = (paddr[15:9] == ptb_pkg::SEL_REGION)
                   && (32'(sel_idx) < ptb_pkg::N_IN)
                   && (paddr[1:0] == 2'h0);
   assign hit_reg  = (paddr == ptb_pkg::EXP_ADDR) || (paddr == ptb_pkg::STAT_A_ADDR)
                   || (paddr == ptb_pkg::STAT_B_ADDR) || (paddr == ptb_pkg::STAT_IN_ADDR);

   always_comb begin
      rd_word = ptb_pkg::RD_ZERO;
      if (hit_term) begin
         rd_word = r_reg.term_mask[t_idx][32*w_idx +: 32];
      end else if (hit_mc) begin
         rd_word = r_reg.mc_cfg[mc_idx];
      end else if (hit_sel) begin
         rd_word = {23'h000000, r_reg.in_sel[sel_idx]};
      end else if (paddr == ptb_pkg::EXP_ADDR) begin
         rd_word = r_reg.exp_en;
      end else if (paddr == ptb_pkg::STAT_A_ADDR) begin
         rd_word = mc_out_a;
      end else if (paddr == ptb_pkg::STAT_B_ADDR) begin
         rd_word = mc_out_b;
      end else if (paddr == ptb_pkg::STAT_IN_ADDR) begin
         rd_word = blk_in[31:0];
      end
   end

   always_comb begin
      r_next       = r_reg;
      r_next.sync1 = {io_in_pin, goe_pin, gpre_pin, grst_pin, gce_pin, gclk_pin};
      r_next.sync2 = r_reg.sync1;
      // Read data and error are captured in the setup cycle so that they
      // come from flops and the access phase can finish without wait states.
      if (setup_ph) begin
         r_next.prdata  = pwrite ? ptb_pkg::RD_ZERO : rd_word;
         r_next.pslverr = ~(hit_term | hit_mc | hit_sel | hit_reg);
      end
      if (wr_en) begin
         if (hit_term) begin
            r_next.term_mask[t_idx][32*w_idx +: 32] = pwdata;
            // Columns past the last array line stay unconnected.
            r_next.term_mask[t_idx][ptb_pkg::TERM_BITS-1:ptb_pkg::N_LINE] = '0;
         end else if (hit_mc) begin
            r_next.mc_cfg[mc_idx] = pwdata;
         end else if (hit_sel) begin
            r_next.in_sel[sel_idx] = pwdata[ptb_pkg::SEL_W-1:0];
         end else if (paddr == ptb_pkg::EXP_ADDR) begin
            r_next.exp_en = pwdata;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata  = r_reg.prdata;
   assign pslverr = r_reg.pslverr & pready;
endmodule

// ---- sim/ptb_asserts.sv ----
`timescale 1ns/1ns
module ptb_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] io_in_pin,
   input wire logic [31:0] mc_out_a,
   input wire logic [47:0] pool_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence unmap_s;
      psel && !penable && paddr >= 16'h3010 ##1 psel && penable;
   endsequence
   sequence skew_s;
      psel && !penable && paddr[1:0] != 2'h0 ##1 psel && penable;
   endsequence
   sequence stat_rd_s;
      psel && !penable && !pwrite && paddr == ptb_pkg::STAT_A_ADDR ##1 psel && penable;
   endsequence
   rdy_access_a: assert property (psel && penable |-> pready)
      else $error("no ready in access");
   rdy_idle_a: assert property (!(psel && penable) |-> !pready)
      else $error("ready outside access");
   err_gate_a: assert property (pslverr |-> pready)
      else $error("error outside access");
   skew_err_a: assert property (skew_s |-> pslverr && prdata == ptb_pkg::RD_ZERO)
      else $error("unaligned access accepted");
   unmap_err_a: assert property (unmap_s |-> pslverr && prdata == ptb_pkg::RD_ZERO)
      else $error("unmapped access accepted");
   stat_rd_a: assert property (stat_rd_s |-> prdata == $past(mc_out_a))
      else $error("status read differs from output A");
   fb_pool_a: assert property (pool_out[31:0] == mc_out_a)
      else $error("internal feedback differs from output A");
   io_pool_a: assert property ($stable(io_in_pin[15:0]) [*3] |->
      pool_out[47:32] == io_in_pin[15:0]) else $error("external feedback differs");
endmodule

bind ptb_logic_block ptb_chk u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .io_in_pin(io_in_pin), .mc_out_a(mc_out_a), .pool_out(pool_out)
);

// ---- sim/ptb_pool_model.sv ----
`timescale 1ns/1ns
module ptb_pool_model (
   input  wire logic         pclk,
   input  wire logic [8:0]   tap_idx,
   input  wire logic         tap_val,
   input  wire logic [31:0]  io_val,
   output logic      [383:0] pool_in,
   output logic      [31:0]  io_in_pin
);
   // Unused lines get fresh noise every cycle, so a wrong select cannot pass by luck.
   logic [383:0] noise_reg = 384'h0;
   always @(posedge pclk) begin
      for (int w = 0; w < 12; w++) begin
         noise_reg[w * 32 +: 32] <= $urandom;
      end
   end
   always_comb begin
      pool_in = noise_reg;
      pool_in[tap_idx] = tap_val;
      io_in_pin = io_val;
   end
endmodule

// ---- sim/ptb_logic_block_tb.sv ----
`timescale 1ns/1ns
module ptb_logic_block_tb;
   localparam int SYNC = 2;
   logic         pclk = 1'b0;
   logic         presetn = 1'b0;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [15:0]  paddr = 16'h0;
   logic [31:0]  pwdata = 32'h0;
   logic [2:0]   gclk_pin = 3'h0;
   logic         gce_pin = 1'b0;
   logic         grst_pin = 1'b0;
   logic         gpre_pin = 1'b0;
   logic         goe_pin = 1'b0;
   logic [8:0]   tap_idx = 9'h0;
   logic         tap_val = 1'b0;
   logic [31:0]  io_val = 32'h0;
   logic [31:0]  prdata, mc_out_a, mc_out_b, io_oe, io_in_pin, rdat, cfg;
   logic [47:0]  pool_out;
   logic [383:0] pool_in;
   logic         pready, pslverr, rerr, x;
   int           err_total = 0;
   int           num_checks = 0;
   int           n, j, c, p;

   ptb_logic_block DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pool_in(pool_in), .gclk_pin(gclk_pin), .gce_pin(gce_pin), .grst_pin(grst_pin),
      .gpre_pin(gpre_pin), .goe_pin(goe_pin), .io_in_pin(io_in_pin), .mc_out_a(mc_out_a),
      .mc_out_b(mc_out_b), .io_oe(io_oe), .pool_out(pool_out)
   );
   ptb_pool_model PM (
      .pclk(pclk), .tap_idx(tap_idx), .tap_val(tap_val), .io_val(io_val),
      .pool_in(pool_in), .io_in_pin(io_in_pin)
   );

   initial begin
      forever #2 pclk = ~pclk;
   end
   function automatic logic [31:0] bt(input int k);
      return 32'h1 << k;
   endfunction
   function automatic logic [15:0] mcw(input int m);
      return 16'(32'h2000 + m * 4);
   endfunction
   // Sharing output m tap t reaches OR input m+t-3, wrapped.
   function automatic int src(input int m, input int t);
      return (m + t + 29) % 32;
   endfunction
   task automatic complete_run;
      if (err_total == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %0h want %0h", $time, m, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Checks sit on falling edges so registered outputs have settled; pins pass two syncs.
   task automatic hold;
      repeat (SYNC + 3) @(negedge pclk);
   endtask
   task automatic pulse;
      @(posedge pclk);
      gclk_pin[0] <= 1'b0;
      hold;
      @(posedge pclk);
      gclk_pin[0] <= 1'b1;
      hold;
   endtask
   task automatic store_test(input int m);
      logic [31:0] base;
      base = bt(ptb_pkg::MC_BYPASS) | bt(ptb_pkg::MC_REG) | bt(ptb_pkg::MC_RST_G);
      base = base | bt(ptb_pkg::MC_PRE_G);
      apb(1'b1, 16'(m * 160), 32'h1);
      apb(1'b1, mcw(m), base);
      tap_val <= 1'b1;
      pulse;
      chk(mc_out_a[m], 1'b1, "edge load");
      @(posedge pclk);
      tap_val <= 1'b0;
      hold;
      chk({mc_out_a[m], mc_out_b[m]}, 2'h2, "dual out");
      // Each load starts from the opposite level and each hold drives opposite data, so a dead path cannot pass.
      @(posedge pclk);
      grst_pin <= 1'b1;
      gpre_pin <= 1'b1;
      hold;
      chk(mc_out_a[m], 1'b0, "reset over preset");
      @(posedge pclk);
      grst_pin <= 1'b0;
      hold;
      chk(mc_out_a[m], 1'b1, "preset");
      @(posedge pclk);
      gpre_pin <= 1'b0;
      apb(1'b1, mcw(m), base | bt(ptb_pkg::MC_CE_USE));
      tap_val <= 1'b0;
      pulse;
      chk(mc_out_a[m], 1'b1, "enable low");
      @(posedge pclk);
      gce_pin <= 1'b1;
      pulse;
      chk(mc_out_a[m], 1'b0, "enable high");
      apb(1'b1, mcw(m), base | bt(ptb_pkg::MC_LATCH));
      tap_val <= 1'b1;
      hold;
      chk(mc_out_a[m], 1'b1, "latch open");
      @(posedge pclk);
      gclk_pin[0] <= 1'b0;
      hold;
      @(posedge pclk);
      tap_val <= 1'b0;
      hold;
      chk(mc_out_a[m], 1'b1, "latch shut");
      // The shared reset term is still unprogrammed and therefore always true.
      apb(1'b1, mcw(m), base | bt(ptb_pkg::MC_RST_PT));
      hold;
      chk(mc_out_a[m], 1'b0, "term reset");
      apb(1'b1, mcw(m), base | bt(ptb_pkg::MC_D_IO));
      for (int v = 1; v >= 0; v--) begin
         @(posedge pclk);
         io_val[m] <= v[0];
         pulse;
         chk(mc_out_a[m], v[0], "io load");
      end
      @(posedge pclk);
      goe_pin <= 1'b1;
      hold;
      chk(io_oe[m], 1'b1, "global enable");
      apb(1'b1, mcw(m), bt(ptb_pkg::MC_OE_PT));
      apb(1'b1, 16'h1440, 32'h3);
      hold;
      chk(io_oe[m], 1'b0, "term enable off");
      apb(1'b1, 16'h1440, 32'h0);
      hold;
      chk(io_oe[m], 1'b1, "term enable on");
   endtask

   initial begin
      void'($urandom(32'h105DDDCE));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(mc_out_a, 32'h0, "outputs after reset");
      // Every logic term ANDs one input with its inverse, so it stays low until opened.
      for (int t = 0; t < 160; t++) apb(1'b1, 16'(t * 32), 32'h3);
      apb(1'b0, 16'h1460, 32'h0);
      chk(rerr, 1'b1, "term past last");
      apb(1'b0, 16'h3010, 32'h0);
      apb(1'b0, 16'h2002, 32'h0);
      apb(1'b1, mcw(5), 32'h123);
      apb(1'b0, mcw(5), 32'h0);
      chk(rdat, 32'h123, "config readback");
      apb(1'b1, mcw(5), 32'h0);
      for (int k = 0; k < 40; k++) begin
         n = k == 1 ? 31 : k == 0 ? 0 : $urandom_range(31);
         j = k == 1 ? 6 : k == 0 ? 0 : $urandom_range(6);
         p = k == 1 ? 383 : $urandom_range(383);
         x = 1'($urandom_range(1));
         c = k % 4 == 3 ? n : src(n, j);
         cfg = k % 4 == 3 ? bt(ptb_pkg::MC_BYPASS) : bt(j);
         cfg = x ? cfg | bt(ptb_pkg::MC_XOR) : cfg;
         tap_idx <= 9'(p);
         apb(1'b1, 16'h2800, 32'(p));
         apb(1'b1, 16'(c * 160), 32'h1);
         apb(1'b1, mcw(n), cfg);
         for (int v = 0; v < 2; v++) begin
            @(posedge pclk);
            tap_val <= v[0];
            hold;
            chk({mc_out_a[n], mc_out_b[n], pool_out[n]}, {3{v[0] ^ x}}, "share");
            apb(1'b0, ptb_pkg::STAT_A_ADDR, 32'h0);
            chk(rdat[n], v[0] ^ x, "status");
         end
         apb(1'b1, 16'(c * 160), 32'h3);
         apb(1'b1, mcw(n), 32'h0);
      end
      // Cluster c reaches macrocell c+1 only through the expander link.
      c = $urandom_range(30);
      n = c + 1;
      apb(1'b1, 16'(c * 160), 32'h1);
      apb(1'b1, ptb_pkg::EXP_ADDR, bt(n));
      apb(1'b1, mcw(n), bt(3));
      for (int v = 0; v < 2; v++) begin
         @(posedge pclk);
         tap_val <= v[0];
         hold;
         chk(mc_out_b[n], v[0], "expander");
      end
      apb(1'b1, ptb_pkg::EXP_ADDR, 32'h0);
      apb(1'b1, 16'(c * 160), 32'h3);
      apb(1'b1, mcw(n), 32'h0);
      store_test($urandom_range(31));
      complete_run;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      complete_run;
   end
endmodule
